// File: verilog/mefr_map.vh
// register offsets, reset values and event bit positions of the event router
// included by the router, its monitor and the testbench
`ifndef MEFR_MAP_VH
`define MEFR_MAP_VH
`define MEFR_ADDR_SPI_MASK 7'h0b
`define MEFR_ADDR_PROTECT 7'h0c
`define MEFR_ADDR_INT_MASK 7'h0d
`define MEFR_ADDR_EVENTS 7'h0e
`define MEFR_RST_SPI_MASK 32'h82029805
`define MEFR_RST_PROTECT 32'h00000000
`define MEFR_RST_INT_MASK 32'h00000000
`define MEFR_RST_EVENTS 32'h00000000
`define MEFR_EV_TARGET 0
`define MEFR_EV_POS_COMP 1
`define MEFR_EV_VEL_HIT 2
`define MEFR_EV_VEL_ZERO 3
`define MEFR_EV_VEL_POS 4
`define MEFR_EV_VEL_NEG 5
`define MEFR_EV_RAMP_CONST 6
`define MEFR_EV_RAMP_UP 7
`define MEFR_EV_RAMP_OTHER 8
`define MEFR_EV_TRAP_MAX 9
`define MEFR_EV_FREEZE 10
`define MEFR_EV_USED 11
`define MEFR_CODE_00 2'h0
`define MEFR_CODE_01 2'h1
`define MEFR_CODE_10 2'h2
`endif

// File: verilog/mefr_flag_store.v
// sticky event flag store: one flip-flop per event bit
// assumes set pulses and clear strobe come from the mclk domain
`timescale 1ns/10ps
`default_nettype none
module mefr_flag_store (
    input wire mclk, // system clock
    input wire reset_n, // synchronous reset, active low
    input wire [31:0] set_pulse, // per bit: condition detected
    input wire clear_rd, // clearing read of the event register
    input wire [31:0] protect, // per bit: keep on read
    output wire [31:0] flags // sticky flags
);
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1)
        begin : g_bit
            reg flag_q;
            always @(posedge mclk)
            begin
                if (!reset_n)
                    flag_q <= 1'b0;
                else if (set_pulse[i])
                    flag_q <= 1'b1; // RULE9
                else if (clear_rd && !protect[i])
                    flag_q <= 1'b0; // RULE2
            end
            assign flags[i] = flag_q;
        end
    endgenerate
endmodule
`default_nettype wire

// File: verilog/mefr_router.v
// event flag collection and routing for the motion controller
// assumes ramp condition inputs are on mclk; freeze pin is asynchronous
// Contract
// RULE1: masked events in the spi status mask drive the eight datagram status bits.
// RULE2: reading the event register clears all events not set in the protect mask.
// RULE3: the interrupt output is the OR of events selected in the interrupt mask.
// RULE4: bits 0, 1 and 2 set on target reached, position compare and velocity hit.
// RULE5: bits 3, 4 and 5 set when the velocity sign code becomes 00, 01 and 10.
// RULE6: bits 6, 7 and 8 set when the ramp phase code becomes 00, 01 and 10.
// RULE7: bit 9 sets when a trapezoid ramp hits limit speed above a nonzero break.
// RULE8: bit 10 sets when the freeze pin goes low, and motion stays held till reset.
// RULE9: each event bit sets on detection and holds until a clearing read.
`timescale 1ns/10ps
`include "mefr_map.vh"
`default_nettype none
module mefr_router (
    input wire mclk, // system clock, 100 MHz
    input wire reset_n, // synchronous reset, active low
    input wire reg_wr, // register write strobe, one cycle
    input wire reg_rd, // register read strobe, one cycle
    input wire [6:0] reg_addr, // register index
    input wire [31:0] reg_wdata, // write data
    output reg [31:0] reg_rdata, // read data, registered
    input wire target_reached, // ramp at target position
    input wire pos_comp_match, // position compare match
    input wire velocity_hit_event, // ramp at configured velocity
    input wire [1:0] velocity_sign_code, // velocity state code
    input wire [1:0] ramp_phase_code, // ramp phase code
    input wire trap_limit_reached, // trapezoid at limit speed, max accel
    input wire [31:0] current_velocity, // signed actual velocity
    input wire [31:0] break_velocity, // break velocity setting
    input wire freeze_in_n, // freeze pin, active low, asynchronous
    output reg [7:0] spi_status_bits, // status bits for each datagram
    output reg interrupt_out, // interrupt output, active high
    output reg motion_freeze // motion held until reset
);
    reg [31:0] spi_mask_q;
    reg [31:0] protect_q;
    reg [31:0] int_mask_q;
    reg [1:0] vel_code_q;
    reg [1:0] ramp_code_q;
    reg codes_valid_q;
    reg [2:0] frz_sync_q;
    reg frz_level_q;
    wire [31:0] flags;
    wire [31:0] set_pulse;
    wire [31:0] vel_mag;
    wire trap_ok;
    wire vel_new;
    wire ramp_new;
    wire freeze_fall;
    wire clear_rd;

    assign clear_rd = reg_rd && (reg_addr == `MEFR_ADDR_EVENTS); // RULE2

    // register writes
    always @(posedge mclk)
    begin
        if (!reset_n)
        begin
            spi_mask_q <= `MEFR_RST_SPI_MASK;
            protect_q <= `MEFR_RST_PROTECT;
            int_mask_q <= `MEFR_RST_INT_MASK;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `MEFR_ADDR_SPI_MASK: spi_mask_q <= reg_wdata;
                `MEFR_ADDR_PROTECT: protect_q <= reg_wdata;
                `MEFR_ADDR_INT_MASK: int_mask_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // register reads, one cycle after the strobe
    always @(posedge mclk)
    begin
        if (!reset_n)
            reg_rdata <= 32'h00000000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `MEFR_ADDR_SPI_MASK: reg_rdata <= spi_mask_q;
                `MEFR_ADDR_PROTECT: reg_rdata <= protect_q;
                `MEFR_ADDR_INT_MASK: reg_rdata <= int_mask_q;
                `MEFR_ADDR_EVENTS: reg_rdata <= flags;
                default: reg_rdata <= 32'h00000000;
            endcase
        end
    end

    // code change detection; first sample after reset counts as a change
    always @(posedge mclk)
    begin
        if (!reset_n)
        begin
            vel_code_q <= 2'h3;
            ramp_code_q <= 2'h3;
            codes_valid_q <= 1'b0;
        end
        else
        begin
            vel_code_q <= velocity_sign_code;
            ramp_code_q <= ramp_phase_code;
            codes_valid_q <= 1'b1;
        end
    end
    assign vel_new = !codes_valid_q || (velocity_sign_code != vel_code_q);
    assign ramp_new = !codes_valid_q || (ramp_phase_code != ramp_code_q);

    // freeze pin: three stages, change accepted when stages two and three agree
    always @(posedge mclk)
    begin
        if (!reset_n)
        begin
            frz_sync_q <= 3'h7;
            frz_level_q <= 1'b1;
            motion_freeze <= 1'b0;
        end
        else
        begin
            frz_sync_q <= {frz_sync_q[1:0], freeze_in_n};
            if (frz_sync_q[1] == frz_sync_q[2])
                frz_level_q <= frz_sync_q[2];
            if (freeze_fall)
                motion_freeze <= 1'b1; // RULE8
        end
    end
    assign freeze_fall = frz_level_q && !frz_sync_q[1] && !frz_sync_q[2];

    assign vel_mag = current_velocity[31] ? (~current_velocity + 32'h1)
                                          : current_velocity;
    assign trap_ok = trap_limit_reached && (break_velocity != 32'h0) &&
                     (vel_mag > break_velocity); // RULE7

    assign set_pulse[`MEFR_EV_TARGET] = target_reached; // RULE4
    assign set_pulse[`MEFR_EV_POS_COMP] = pos_comp_match; // RULE4
    assign set_pulse[`MEFR_EV_VEL_HIT] = velocity_hit_event; // RULE4
    assign set_pulse[`MEFR_EV_VEL_ZERO] = vel_new &&
        (velocity_sign_code == `MEFR_CODE_00); // RULE5
    assign set_pulse[`MEFR_EV_VEL_POS] = vel_new &&
        (velocity_sign_code == `MEFR_CODE_01); // RULE5
    assign set_pulse[`MEFR_EV_VEL_NEG] = vel_new &&
        (velocity_sign_code == `MEFR_CODE_10); // RULE5
    assign set_pulse[`MEFR_EV_RAMP_CONST] = ramp_new &&
        (ramp_phase_code == `MEFR_CODE_00); // RULE6
    assign set_pulse[`MEFR_EV_RAMP_UP] = ramp_new &&
        (ramp_phase_code == `MEFR_CODE_01); // RULE6
    assign set_pulse[`MEFR_EV_RAMP_OTHER] = ramp_new &&
        (ramp_phase_code == `MEFR_CODE_10); // RULE6
    assign set_pulse[`MEFR_EV_TRAP_MAX] = trap_ok; // RULE7
    assign set_pulse[`MEFR_EV_FREEZE] = freeze_fall; // RULE8
    // upper event sources are not part of this block
    assign set_pulse[31:`MEFR_EV_USED] = 21'h000000;

    mefr_flag_store u_store (
        .mclk(mclk),
        .reset_n(reset_n),
        .set_pulse(set_pulse),
        .clear_rd(clear_rd),
        .protect(protect_q),
        .flags(flags)
    );

    // routing outputs, registered
    always @(posedge mclk)
    begin
        if (!reset_n)
        begin
            spi_status_bits <= 8'h00;
            interrupt_out <= 1'b0;
        end
        else
        begin
            spi_status_bits <= flags[7:0] & spi_mask_q[7:0]; // RULE1
            interrupt_out <= |(flags & int_mask_q); // RULE3
        end
    end
endmodule
`default_nettype wire

// File: test/mefr_host.sv
// host model: issues one-cycle register strobes on the router bus
// assumes the bench calls wr and rd from one process
`timescale 1ns/10ps
`default_nettype none
module mefr_host (
    input wire logic mclk, // clock
    output logic reg_wr, // write strobe
    output logic reg_rd, // read strobe
    output logic [6:0] reg_addr, // index
    output logic [31:0] reg_wdata, // write data
    input wire logic [31:0] reg_rdata // read data
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, output logic [31:0] q);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
endmodule
`default_nettype wire

// File: test/mefr_monitor.sv
// port assertions for the event router
// bound to every router instance; masks tracked from bus writes
`timescale 1ns/10ps
`include "mefr_map.vh"
`default_nettype none
module mefr_monitor (
    input wire logic mclk, reset_n, reg_wr, reg_rd, freeze_in_n,
    input wire logic target_reached, pos_comp_match, interrupt_out,
    input wire logic motion_freeze, // freeze state
    input wire logic [1:0] velocity_sign_code, ramp_phase_code, // codes
    input wire logic [6:0] reg_addr, // index
    input wire logic [31:0] reg_wdata, reg_rdata, // bus data
    input wire logic [7:0] spi_status_bits // status
);
    logic [31:0] sm_q, im_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    always_ff @(posedge mclk)
        if (!reset_n)
        begin
            sm_q <= `MEFR_RST_SPI_MASK;
            im_q <= `MEFR_RST_INT_MASK;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `MEFR_ADDR_SPI_MASK) sm_q <= reg_wdata;
            if (reg_addr == `MEFR_ADDR_INT_MASK) im_q <= reg_wdata;
        end
    a_spi_tgt: assert property (target_reached && sm_q[0]
        |-> ##2 spi_status_bits[0]) else $error("spi bit0 missing");
    a_spi_masked: assert property ((spi_status_bits
        & ~$past(sm_q[7:0])) == 8'h00) else $error("unmasked spi bit");
    a_rd_spi_mask: assert property (reg_rd
        && reg_addr == `MEFR_ADDR_SPI_MASK |=> reg_rdata == $past(sm_q))
        else $error("spi mask readback");
    a_pc_int: assert property (pos_comp_match && im_q[1]
        |-> ##2 interrupt_out) else $error("interrupt missing");
    a_int_cause: assert property (interrupt_out
        |-> $past(im_q) != 32'h0) else $error("interrupt unmasked");
    a_vel_neg: assert property ($changed(velocity_sign_code)
        && velocity_sign_code == `MEFR_CODE_10 && sm_q[5]
        |-> ##2 spi_status_bits[5]) else $error("velocity bit missing");
    a_ramp_up: assert property ($changed(ramp_phase_code)
        && ramp_phase_code == `MEFR_CODE_01 && sm_q[7]
        |-> ##2 spi_status_bits[7]) else $error("ramp bit missing");
    a_freeze_set: assert property ($fell(freeze_in_n)
        |-> ##[1:6] motion_freeze) else $error("freeze late");
    a_freeze_hold: assert property (motion_freeze
        |=> motion_freeze) else $error("freeze dropped");
endmodule
bind mefr_router mefr_monitor u_mon (.*);
`default_nettype wire

// File: test/testbench.sv
// self-checking bench for the event router
// host model drives the register bus; events come from row table
`timescale 1ns/10ps
`include "mefr_map.vh"
`default_nettype none
module testbench;
    logic mclk = 1'b0, reset_n = 1'b0, frz_n = 1'b1;
    logic [7:0] st = 8'h1e;
    logic [31:0] vel = 32'h0, brk = 32'h0, q;
    wire logic reg_wr, reg_rd, irq, mfz;
    wire logic [6:0] reg_addr;
    wire logic [31:0] reg_wdata, reg_rdata;
    wire logic [7:0] spi;
    int err_total = 0, compares = 0, cyc = 0;
    // row: {target, compare, vel hit, sign code, phase code, trap}
    logic [7:0] rs [13] = '{8'h9e, 8'h5e, 8'h3e, 8'h06, 8'h0e, 8'h16,
        8'h18, 8'h1a, 8'h1c, 8'h1f, 8'h1f, 8'h1f, 8'h1f};
    logic [31:0] rv [13] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h0, 32'h64, 32'hffffff9c, 32'h64, 32'h32};
    logic [31:0] rb [13] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h0, 32'h32, 32'h32, 32'h0, 32'h32};
    logic [31:0] re [13] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h10, 32'h20,
        32'h40, 32'h80, 32'h100, 32'h200, 32'h200, 32'h0, 32'h0};
    mefr_host host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    mefr_router DUT (.mclk(mclk), .reset_n(reset_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .target_reached(st[7]),
        .pos_comp_match(st[6]), .velocity_hit_event(st[5]),
        .velocity_sign_code(st[4:3]), .ramp_phase_code(st[2:1]),
        .trap_limit_reached(st[0]), .current_velocity(vel),
        .break_velocity(brk), .freeze_in_n(frz_n),
        .spi_status_bits(spi), .interrupt_out(irq), .motion_freeze(mfz));
    always #5 mclk = ~mclk;
    task ck(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task rdc(input logic [6:0] a, input logic [31:0] e);
        host.rd(a, q);
        ck("register", e, q);
    endtask
    task end_sim;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            err_total++;
            end_sim;
        end
    end
    initial
    begin
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        rdc(`MEFR_ADDR_SPI_MASK, `MEFR_RST_SPI_MASK);
        rdc(`MEFR_ADDR_PROTECT, 32'h0);
        rdc(`MEFR_ADDR_INT_MASK, 32'h0);
        rdc(`MEFR_ADDR_EVENTS, 32'h0);
        host.wr(`MEFR_ADDR_SPI_MASK, 32'ha5a5a5a5);
        rdc(`MEFR_ADDR_SPI_MASK, 32'ha5a5a5a5);
        foreach (rs[i])
        begin
            @(posedge mclk);
            st <= rs[i];
            vel <= rv[i];
            brk <= rb[i];
            @(posedge mclk);
            st <= 8'h1e;
            rdc(`MEFR_ADDR_EVENTS, re[i]);
        end
        host.wr(`MEFR_ADDR_PROTECT, 32'h1);
        host.wr(`MEFR_ADDR_INT_MASK, 32'h2);
        @(posedge mclk) st <= 8'hde;
        @(posedge mclk) st <= 8'h1e;
        @(posedge mclk);
        #1 ck("interrupt", 32'h1, irq);
        ck("spi bits", 32'h1, spi);
        host.wr(`MEFR_ADDR_EVENTS, 32'hffffffff);
        host.wr(7'h20, 32'hffffffff);
        rdc(7'h20, 32'h0);
        rdc(`MEFR_ADDR_EVENTS, 32'h3);
        rdc(`MEFR_ADDR_EVENTS, 32'h1);
        repeat (2) @(posedge mclk);
        #1 ck("interrupt", 32'h0, irq);
        @(posedge mclk) frz_n <= 1'b0;
        repeat (8) @(posedge mclk);
        #1 ck("freeze", 32'h1, mfz);
        @(posedge mclk) frz_n <= 1'b1;
        rdc(`MEFR_ADDR_EVENTS, 32'h401);
        rdc(`MEFR_ADDR_EVENTS, 32'h1);
        ck("freeze", 32'h1, mfz);
        @(posedge mclk) reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        #1 ck("freeze", 32'h0, mfz);
        rdc(`MEFR_ADDR_PROTECT, 32'h0);
        end_sim;
    end
endmodule
`default_nettype wire
